/* File: src/ubie_defs.svh */
// constants for the bulk in frame encapsulator
`ifndef UBIE_DEFS_SVH
`define UBIE_DEFS_SVH

// staging buffer: 2K words of 32 bits (8 KB)
`define UBIE_BUF_AW 11
`define UBIE_BUF_DEPTH 2048
`define UBIE_PTR_W 12
`define UBIE_WORD_W 32

// packet-length queue: 32 entries
`define UBIE_CQ_AW 5
`define UBIE_CQ_DEPTH 32
`define UBIE_CQ_PW 6
`define UBIE_LEN_W 11

// frame length field of the first command word
`define UBIE_FLEN_LSB 0
`define UBIE_FLEN_W 14
`define UBIE_CMD_BYTES 16'h000c
`define UBIE_REM_W 16

// link speeds and their largest packet sizes
`define UBIE_SPD_FS 2'h0
`define UBIE_SPD_HS 2'h1
`define UBIE_SPD_SS 2'h2
`define UBIE_MPS_FS 11'h040
`define UBIE_MPS_HS 11'h200
`define UBIE_MPS_SS 11'h400
`define UBIE_BURST_W 5

`endif

/* File: src/ubie_pkg.sv */
// types of the bulk in frame encapsulator
`include "ubie_defs.svh"

package ubie_pkg;

  // gray coded along idle -> data -> end
  typedef enum logic [1:0] {
    UBIE_IDLE = 2'h0,
    UBIE_DATA = 2'h1,
    UBIE_ENDF = 2'h3
  } ubie_state_e;

  typedef struct packed {
    ubie_state_e state;
    logic [`UBIE_BUF_DEPTH-1:0][`UBIE_WORD_W-1:0] mem;
    logic [`UBIE_PTR_W-1:0] wp;
    logic [`UBIE_PTR_W-1:0] rp;
    logic [`UBIE_CQ_DEPTH-1:0][`UBIE_LEN_W-1:0] cq;
    logic [`UBIE_CQ_PW-1:0] cwp;
    logic [`UBIE_CQ_PW-1:0] crp;
    logic [`UBIE_LEN_W-1:0] cur_len;
    logic [`UBIE_REM_W-1:0] rem;
    logic [`UBIE_BURST_W-1:0] burst;
    logic rx_rd;
    logic [`UBIE_WORD_W-1:0] udc_data;
    logic [`UBIE_LEN_W-1:0] pkt_len;
    logic [`UBIE_CQ_PW-1:0] pkt_count;
    logic cmd_full;
    logic [`UBIE_PTR_W-1:0] buf_words;
  } ubie_state_s;

endpackage

/* File: src/ubie_framer.sv */
// bulk in transmitter: packs received frames into usb bulk in packets
`timescale 1ns/100ps

module ubie_framer
  import ubie_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_frame_ready,
  input wire logic [`UBIE_WORD_W-1:0] rx_data,
  output logic rx_rd,
  input wire logic multi_frame_mode,
  input wire logic [1:0] link_speed,
  input wire logic [`UBIE_BURST_W-1:0] superspeed_burst_limit,
  input wire logic udc_word_rd,
  input wire logic udc_pkt_done,
  output logic [`UBIE_WORD_W-1:0] udc_data,
  output logic [`UBIE_LEN_W-1:0] pkt_len,
  output logic [`UBIE_CQ_PW-1:0] pkt_count,
  output logic cmd_full,
  output logic [`UBIE_PTR_W-1:0] buf_words
);

  // ****************************************
  // helper functions
  // ****************************************

  // largest bulk in packet for the current speed
  function automatic logic [`UBIE_LEN_W-1:0] max_pkt(
    input logic [1:0] spd
  );
    logic [`UBIE_LEN_W-1:0] m;
    case (spd)
      `UBIE_SPD_SS: m = `UBIE_MPS_SS;
      `UBIE_SPD_HS: m = `UBIE_MPS_HS;
      default: m = `UBIE_MPS_FS;
    endcase
    return m;
  endfunction

  // bytes that the next word carries, four or the rest
  function automatic logic [2:0] word_bytes(
    input logic [`UBIE_REM_W-1:0] r
  );
    logic [2:0] b;
    if (r >= `UBIE_REM_W'(4)) begin
      b = 3'h4;
    end else begin
      b = r[2:0];
    end
    return b;
  endfunction

  // clear bytes beyond the last valid one
  function automatic logic [`UBIE_WORD_W-1:0] keep_bytes(
    input logic [`UBIE_WORD_W-1:0] w,
    input logic [2:0] n
  );
    logic [`UBIE_WORD_W-1:0] o;
    o = w;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) >= n) begin
        o[i*8 +: 8] = 8'h00;
      end
    end
    return o;
  endfunction

  // ****************************************
  // state
  // ****************************************

  ubie_state_s s;
  ubie_state_s next_s;

  // decoded views of the current state
  logic [`UBIE_LEN_W-1:0] mps;
  logic [`UBIE_PTR_W-1:0] fill;
  logic [`UBIE_PTR_W-1:0] room;
  logic [`UBIE_CQ_PW-1:0] cq_used;
  logic cq_full;
  logic cq_empty;
  logic [`UBIE_REM_W-1:0] frame_bytes;
  logic [`UBIE_REM_W-1:0] need_words;
  logic burst_hit;

  // ****************************************
  // decode
  // ****************************************

  // fill levels and limits seen by the mover
  always_comb begin
    mps = max_pkt(link_speed);
    fill = s.wp - s.rp;
    room = `UBIE_PTR_W'(`UBIE_BUF_DEPTH) - fill;
    cq_used = s.cwp - s.crp;
    cq_full = cq_used == `UBIE_CQ_PW'(`UBIE_CQ_DEPTH);
    cq_empty = cq_used == `UBIE_CQ_PW'(0);
    // frame length excludes the three command words and pad
    frame_bytes = `UBIE_REM_W'(rx_data[`UBIE_FLEN_LSB +: `UBIE_FLEN_W])
      + `UBIE_CMD_BYTES;
    need_words = (frame_bytes + `UBIE_REM_W'(3)) >> 2;
    burst_hit = (link_speed == `UBIE_SPD_SS)
      && (s.burst >= superspeed_burst_limit);
  end

  // ****************************************
  // next state
  // ****************************************

  always_comb begin
    logic [2:0] nb;
    logic [`UBIE_LEN_W-1:0] grown;
    logic [`UBIE_LEN_W-1:0] padded;
    logic push;
    logic [`UBIE_LEN_W-1:0] push_len;
    nb = word_bytes(s.rem);
    grown = s.cur_len + `UBIE_LEN_W'(nb);
    padded = (s.cur_len + `UBIE_LEN_W'(3)) & ~`UBIE_LEN_W'(3);
    push = 1'b0;
    push_len = '0;
    next_s = s;
    next_s.rx_rd = 1'b0;

    // controller drains words; reads on an empty buffer are ignored
    if (udc_word_rd && (fill != '0)) begin
      next_s.rp = s.rp + `UBIE_PTR_W'(1);
    end
    // controller retires the head packet length
    if (udc_pkt_done && !cq_empty) begin
      next_s.crp = s.crp + `UBIE_CQ_PW'(1);
    end

    case (s.state)
      // wait for a whole frame and room for all of it
      UBIE_IDLE: begin
        if (rx_frame_ready && !s.rx_rd && !cq_full
            && (`UBIE_REM_W'(room) >= need_words)) begin
          next_s.rem = frame_bytes;
          next_s.state = UBIE_DATA;
        end
      end

      // move one word every other cycle; the source pops a cycle late
      UBIE_DATA: begin
        if (!s.rx_rd && !cq_full) begin
          next_s.mem[s.wp[`UBIE_BUF_AW-1:0]] = keep_bytes(rx_data, nb);
          next_s.wp = s.wp + `UBIE_PTR_W'(1);
          next_s.rx_rd = 1'b1;
          next_s.rem = s.rem - `UBIE_REM_W'(nb);
          // full packet closes here; the rest of the frame goes on
          if (grown == mps) begin
            push = 1'b1;
            push_len = mps;
            next_s.cur_len = '0;
            next_s.burst = s.burst + `UBIE_BURST_W'(1);
          end else begin
            next_s.cur_len = grown;
          end
          if (s.rem <= `UBIE_REM_W'(4)) begin
            next_s.state = UBIE_ENDF;
          end
        end
      end

      // decide pad or close once the source has settled its pop
      UBIE_ENDF: begin
        if (!s.rx_rd && !cq_full) begin
          if (multi_frame_mode && rx_frame_ready && !burst_hit) begin
            // pad bytes count in the packet length
            if (padded == mps) begin
              push = 1'b1;
              push_len = mps;
              next_s.cur_len = '0;
              next_s.burst = s.burst + `UBIE_BURST_W'(1);
            end else begin
              next_s.cur_len = padded;
            end
          end else begin
            // short packet, or zero length on an exact multiple
            push = 1'b1;
            push_len = s.cur_len;
            next_s.cur_len = '0;
            next_s.burst = '0;
          end
          next_s.state = UBIE_IDLE;
        end
      end

      default: begin
        next_s.state = UBIE_IDLE;
      end
    endcase

    // queue every finished packet length, zero included
    if (push) begin
      next_s.cq[s.cwp[`UBIE_CQ_AW-1:0]] = push_len;
      next_s.cwp = s.cwp + `UBIE_CQ_PW'(1);
    end

    // an empty buffer means the burst has drained
    if ((next_s.wp == next_s.rp) && (s.state == UBIE_IDLE)) begin
      next_s.burst = '0;
    end

    // registered views for the controller
    next_s.udc_data = next_s.mem[next_s.rp[`UBIE_BUF_AW-1:0]];
    next_s.pkt_len = next_s.cq[next_s.crp[`UBIE_CQ_AW-1:0]];
    next_s.pkt_count = next_s.cwp - next_s.crp;
    next_s.cmd_full = (next_s.cwp - next_s.crp)
      == `UBIE_CQ_PW'(`UBIE_CQ_DEPTH);
    next_s.buf_words = next_s.wp - next_s.rp;
  end

  // ****************************************
  // registers
  // ****************************************

  // storage keeps contents over reset; pointers and control clear
  always_ff @(posedge clk) begin
    if (reset) begin
      s <= s;
      s.state <= UBIE_IDLE;
      s.wp <= '0;
      s.rp <= '0;
      s.cwp <= '0;
      s.crp <= '0;
      s.cur_len <= '0;
      s.rem <= '0;
      s.burst <= '0;
      s.rx_rd <= 1'b0;
      s.udc_data <= '0;
      s.pkt_len <= '0;
      s.pkt_count <= '0;
      s.cmd_full <= 1'b0;
      s.buf_words <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign rx_rd = s.rx_rd;
  assign udc_data = s.udc_data;
  assign pkt_len = s.pkt_len;
  assign pkt_count = s.pkt_count;
  assign cmd_full = s.cmd_full;
  assign buf_words = s.buf_words;

endmodule

/* File: verif/ubie_framer_checker.sv */
// port assertions for the bulk in framer
`timescale 1ns/100ps
`include "ubie_defs.svh"
module ubie_framer_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic rx_frame_ready,
  input wire logic rx_rd,
  input wire logic [1:0] link_speed,
  input wire logic udc_word_rd,
  input wire logic udc_pkt_done,
  input wire logic [`UBIE_LEN_W-1:0] pkt_len,
  input wire logic [`UBIE_CQ_PW-1:0] pkt_count,
  input wire logic cmd_full,
  input wire logic [`UBIE_PTR_W-1:0] buf_words
);
  // ****
  // rules
  // ****
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [`UBIE_LEN_W-1:0] mps;
  // largest packet for the speed in use
  assign mps = link_speed == `UBIE_SPD_SS ? `UBIE_MPS_SS : link_speed == `UBIE_SPD_HS ? `UBIE_MPS_HS : `UBIE_MPS_FS;
  a_full_flag: assert property (cmd_full == (pkt_count == 6'h20))
    else $error("full flag disagrees with count");
  a_count_max: assert property (pkt_count <= 6'h20)
    else $error("length queue above 32");
  // the pop that closes a full packet may coincide with the queue filling
  a_full_stall: assert property ($past(cmd_full) |-> !rx_rd)
    else $error("pop while queue full");
  a_rd_pulse: assert property (rx_rd |=> !rx_rd)
    else $error("pop longer than one cycle");
  a_rd_cause: assert property ($rose(rx_rd) |-> $past(rx_frame_ready) || $past(rx_frame_ready, 2))
    else $error("pop without a whole frame");
  a_len_limit: assert property (pkt_count != 6'h00 |-> pkt_len <= mps)
    else $error("packet above max size");
  a_len_retire: assert property (udc_pkt_done && pkt_count != 6'h00 |=> pkt_count <= $past(pkt_count))
    else $error("retire did not lower count");
  a_word_retire: assert property (udc_word_rd && buf_words != 12'h000 |=> buf_words <= $past(buf_words))
    else $error("read did not lower fill");
  a_buf_max: assert property (buf_words <= 12'h800)
    else $error("fill above 2048 words");
endmodule
bind ubie_framer ubie_framer_checker i_ubie_framer_checker (.clk(clk), .reset(reset),
  .rx_frame_ready(rx_frame_ready), .rx_rd(rx_rd), .link_speed(link_speed), .udc_word_rd(udc_word_rd),
  .udc_pkt_done(udc_pkt_done), .pkt_len(pkt_len), .pkt_count(pkt_count), .cmd_full(cmd_full),
  .buf_words(buf_words));

/* File: verif/ubie_rx_source.sv */
// receive fifo model: show-ahead head word, whole frames only
`timescale 1ns/100ps
module ubie_rx_source (
  input wire logic clk,
  input wire logic rx_rd,
  output logic rx_frame_ready,
  output logic [31:0] rx_data
);
  logic [32:0] q[$];
  int nfr = 0;
  initial begin
    rx_frame_ready = 1'b0;
    rx_data = 32'h0;
  end
  // bench loads a frame in one go, so ready never shows a partial one
  task put(input logic [31:0] w, input logic last);
    q.push_back({last, w});
    nfr += int'(last);
  endtask
  // pop on the pulse; empty head toggles so stale data never matches
  always @(posedge clk) begin
    if (rx_rd && q.size() != 0) begin
      nfr -= int'(q[0][32]);
      void'(q.pop_front());
    end
    rx_frame_ready <= nfr > 0;
    rx_data <= q.size() != 0 ? q[0][31:0] : ~rx_data;
  end
endmodule

/* File: verif/tb_ubie_framer.sv */
// self-checking bench for the bulk in framer
`timescale 1ns/100ps
`include "ubie_defs.svh"
module tb_ubie_framer;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic rx_frame_ready;
  logic [31:0] rx_data;
  logic rx_rd;
  logic multi_frame_mode = 1'b0;
  logic [1:0] link_speed = `UBIE_SPD_HS;
  logic udc_word_rd = 1'b0;
  logic udc_pkt_done = 1'b0;
  logic [4:0] burst_limit = 5'h04;
  logic [31:0] udc_data;
  logic [10:0] pkt_len;
  logic [5:0] pkt_count;
  logic cmd_full;
  logic [11:0] buf_words;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int n_checks = 0;
  always #10 clk = ~clk;
  ubie_rx_source i_ubie_rx_source (.clk(clk), .rx_rd(rx_rd), .rx_frame_ready(rx_frame_ready), .rx_data(rx_data));
  ubie_framer i_ubie_framer (.clk(clk), .reset(reset), .rx_frame_ready(rx_frame_ready), .rx_data(rx_data),
    .rx_rd(rx_rd), .multi_frame_mode(multi_frame_mode), .link_speed(link_speed), .superspeed_burst_limit(burst_limit),
    .udc_word_rd(udc_word_rd), .udc_pkt_done(udc_pkt_done), .udc_data(udc_data), .pkt_len(pkt_len),
    .pkt_count(pkt_count), .cmd_full(cmd_full), .buf_words(buf_words));
  // ****
  // helpers
  // ****
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // frame of len bytes plus three command words, unused tail bytes zero
  task send(input int len);
    logic [31:0] w;
    int i;
    int k;
    for (i = 0; i < (len + 15) / 4; i++) begin
      for (k = 0; k < 4; k++)
        w[8*k+:8] = (i * 4 + k < len + 12) ? 8'(i * 4 + k + 90) : 8'h00;
      if (i == 0)
        w = 32'(len);
      i_ubie_rx_source.put(w, i == (len + 15) / 4 - 1);
      exp_q.push_back(w);
    end
  endtask
  task wait_cnt(input logic [5:0] n);
    int i;
    for (i = 0; i < 4000 && pkt_count !== n; i++)
      @(negedge clk);
    repeat (4) @(negedge clk);
    chk(32'(pkt_count), 32'(n));
  endtask
  task pop_len(input logic [10:0] n);
    int i;
    for (i = 0; i < 4000 && pkt_count === 6'h00; i++)
      @(negedge clk);
    chk(32'(pkt_len), 32'(n));
    udc_pkt_done = 1'b1;
    @(negedge clk);
    udc_pkt_done = 1'b0;
    @(negedge clk);
  endtask
  // controller reads whole words and checks the unused tail bytes as zero
  task drain();
    while (exp_q.size() != 0) begin
      chk(udc_data, exp_q.pop_front());
      udc_word_rd = 1'b1;
      @(negedge clk);
      udc_word_rd = 1'b0;
      @(negedge clk);
    end
    chk(32'(buf_words), 32'h0);
  endtask
  // ****
  // scenarios
  // ****
  task t_single();
    chk(32'(pkt_count), 32'h0);
    send(5);
    wait_cnt(6'h01);
    pop_len(11'd17);
    drain();
  endtask
  task t_zlp();
    link_speed = `UBIE_SPD_FS;
    send(52);
    wait_cnt(6'h02);
    pop_len(11'd64);
    pop_len(11'd0);
    drain();
  endtask
  task t_multi();
    multi_frame_mode = 1'b1;
    link_speed = `UBIE_SPD_HS;
    send(5);
    send(9);
    wait_cnt(6'h01);
    pop_len(11'd41);
    drain();
  endtask
  task t_split();
    link_speed = `UBIE_SPD_FS;
    send(100);
    wait_cnt(6'h02);
    pop_len(11'd64);
    pop_len(11'd48);
    drain();
  endtask
  // queue fills before the buffer does; extra frame must wait
  task t_full();
    int i;
    multi_frame_mode = 1'b0;
    for (i = 0; i < 17; i++)
      send(52);
    wait_cnt(6'h20);
    chk(32'(cmd_full), 32'h1);
    chk(32'(buf_words), 32'h100);
    for (i = 0; i < 17; i++) begin
      pop_len(11'd64);
      pop_len(11'd0);
    end
    drain();
  endtask
  // one full packet hits a limit of one, so the burst closes with a zlp
  task t_burst();
    multi_frame_mode = 1'b1;
    link_speed = `UBIE_SPD_SS;
    burst_limit = 5'h01;
    send(1012);
    send(5);
    wait_cnt(6'h03);
    pop_len(11'd1024);
    pop_len(11'd0);
    pop_len(11'd17);
    drain();
  endtask
  task conclude();
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    t_single();
    t_zlp();
    t_multi();
    t_split();
    t_full();
    t_burst();
    conclude();
  end
  // the run needs a few thousand cycles; this cuts a hang
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
endmodule
